/* File: include/dre_defines.vh */
`ifndef DRE_DEFINES_VH
`define DRE_DEFINES_VH

// APB register map
`define DRE_CTRL_OFS        8'h00
`define DRE_STAT_OFS        8'h04
`define DRE_CTRL_RST        32'h0000_0000
`define DRE_CTRL_MASK       32'h0000_ff1f

// Control fields
`define DRE_CTRL_SERR_EN    0
`define DRE_CTRL_PRI_MTO    1
`define DRE_CTRL_SEC_MTO    2
`define DRE_CTRL_PF_DIS     3
`define DRE_CTRL_DSERR_EN   4
`define DRE_CTRL_CLS_LO     8
`define DRE_CTRL_CLS_HI     15

// Status fields
`define DRE_STAT_QCNT_LO    0
`define DRE_STAT_QCNT_HI    1
`define DRE_STAT_FLOW       2
`define DRE_STAT_DONE       3
`define DRE_STAT_ABORT      4
`define DRE_STAT_TST_LO     5
`define DRE_STAT_TST_HI     6
`define DRE_STAT_BCNT_LO    8
`define DRE_STAT_BCNT_HI    13

// Queue and buffer sizes
`define DRE_QUEUE_DEPTH     2'd3
`define DRE_BUF_DEPTH       6'd32
`define DRE_BOUND_DW        7'd16

// Bus commands
`define DRE_CMD_IORD        4'h2
`define DRE_CMD_MR          4'h6
`define DRE_CMD_CFGRD       4'ha
`define DRE_CMD_MRM         4'hc
`define DRE_CMD_MRL         4'he

// Timing counts (in attempts and clocks)
`define DRE_RETRY_LIMIT     25'h100_0000
`define DRE_DISCARD_SHORT   16'h8000
`define DRE_DISCARD_LONG    16'h0400

`endif

/* File: hw/dre_read_engine.v */
// Summary of operation
// R1: Every read is a delayed transaction
// R2: Latch address, command, parity, first byte enables
// R3: Retry initiator after capturing new request
// R4: Initiator repeats read until data or abort
// R5: Head entry, writes drained, then request bus
// R6: Nonprefetch forwards enables, prefetch drives zeros
// R7: Target retry makes engine reissue read
// R8: No refetch after data then termination
// R9: After 2^24 attempts abort and drop entry
// R10: Limit abort asserts system error if enabled
// R11: Returned data goes to opposite read queue
// R12: Accept one Dword per clock, no waits
// R13: Deliver only when complete, ordered, at head
// R14: Memory read commands alias when matching
// R15: Disconnect with last Dword, discard leftovers
// R16: Early take while fetching enters flow-through
// R17: Flow-through ends: initiator, 4KB, buffer full
// R18: Empty buffer stalls ready, otherwise none
// R19: Initiator end forwarded, leftover data discarded
// R20: Discard timer starts, value from timeout bits
// R21: Timer expiry drops entry, optional system error
// R22: Three entries per direction, duplicates ignored
// R23: Nonprefetch fetches one Dword, disconnects after
// R24: Prefetch policy by direction and command
// R25: Prefetch stops at cache line or 16-Dword; memory read multiple stops at two cache lines or 32 Dwords
// R26: Discard start values are parameters
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/100ps
`include "dre_defines.vh"

module dre_read_engine #(
	parameter        UPSTREAM      = 0,
	parameter [24:0] RETRY_LIMIT   = `DRE_RETRY_LIMIT,
	parameter [15:0] DISCARD_SHORT = `DRE_DISCARD_SHORT,
	parameter [15:0] DISCARD_LONG  = `DRE_DISCARD_LONG
) (
	input  wire        ref_clk,
	input  wire        reset_n,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire        iniReq,
	input  wire [31:0] iniAddr,
	input  wire [3:0]  iniCmd,
	input  wire        iniPar,
	input  wire [3:0]  iniBe,
	input  wire        iniPrefSpace,
	input  wire        iniTake,
	input  wire        iniStop,
	input  wire        rdOrderOk,
	output reg         iniRetry,
	output reg         iniAbort,
	output reg         iniTrdy,
	output reg  [31:0] iniData,
	output reg         iniDisc,
	input  wire        pwDrained,
	input  wire        tgtGnt,
	input  wire [31:0] tgtData,
	input  wire        tgtDataValid,
	input  wire        tgtRetry,
	input  wire        tgtAbort,
	input  wire        tgtEnd,
	output reg         tgtReq,
	output reg         tgtStart,
	output reg  [31:0] tgtAddr,
	output reg  [3:0]  tgtCmd,
	output reg  [3:0]  tgtBe,
	output reg         tgtPar,
	output reg         tgtLast,
	output reg         sysErrN
);

	localparam [1:0] TS_IDLE = 2'b00;
	localparam [1:0] TS_ARB  = 2'b01;
	localparam [1:0] TS_DATA = 2'b10;

	function isMemRd;
		input [3:0] c;
		isMemRd = (c == `DRE_CMD_MR) || (c == `DRE_CMD_MRL) || (c == `DRE_CMD_MRM);
	endfunction

	function cmdMatch;
		input [3:0] a;
		input [3:0] b;
		cmdMatch = (a == b) || (isMemRd(a) && isMemRd(b)); // [R14]
	endfunction

	// Dwords to fetch before the prefetch boundary
	function [6:0] fetchLimit;
		input       pf;
		input [3:0] c;
		input [7:0] cache_line_size_setting;
		input [5:0] dw;
		reg         clsOk;
		reg   [6:0] span;
		begin
			clsOk = (cache_line_size_setting == 8'h01) || (cache_line_size_setting == 8'h02) || (cache_line_size_setting == 8'h04) || (cache_line_size_setting == 8'h08);
			span  = clsOk ? {cache_line_size_setting[5:0], 1'b0} : {1'b0, `DRE_BUF_DEPTH};
			if (!pf)
				fetchLimit = 7'd1; // [R23]
			else if (c == `DRE_CMD_MRM)
				fetchLimit = span - ({1'b0, dw} & (span - 7'd1));
			else if (clsOk)
				fetchLimit = {cache_line_size_setting[6:0]} - ({1'b0, dw} & (cache_line_size_setting[6:0] - 7'd1)); // [R25]
			else
				fetchLimit = `DRE_BOUND_DW - ({1'b0, dw} & (`DRE_BOUND_DW - 7'd1)); // [R25]
		end
	endfunction

	reg  [31:0] ctrl_q;
	reg  [1:0]  qCnt_q;
	reg  [31:0] eAddr [0:2];
	reg  [3:0]  eCmd  [0:2];
	reg         ePar  [0:2];
	reg  [3:0]  eBe   [0:2];
	reg         ePref [0:2];
	reg  [31:0] buf_q [0:31];
	reg  [4:0]  wrPtr_q;
	reg  [4:0]  rdPtr_q;
	reg  [5:0]  bufCnt_q;
	reg  [1:0]  tState_q;
	reg  [6:0]  remain_q;
	reg  [31:0] fetchAddr_q;
	reg  [24:0] attempts_q;
	reg         headDone_q;
	reg         headAbort_q;
	reg         killFetch_q;
	reg         busy_q;
	reg         flow_q;
	reg  [15:0] discard_q;

	wire [7:0]  cache_line_size_setting      = ctrl_q[`DRE_CTRL_CLS_HI:`DRE_CTRL_CLS_LO];
	wire        serrEn   = ctrl_q[`DRE_CTRL_SERR_EN];
	wire        mtoSel   = UPSTREAM ? ctrl_q[`DRE_CTRL_SEC_MTO] : ctrl_q[`DRE_CTRL_PRI_MTO];
	wire        newPref  = (iniCmd == `DRE_CMD_MRL) || (iniCmd == `DRE_CMD_MRM) ||
		((iniCmd == `DRE_CMD_MR) && (UPSTREAM ? !ctrl_q[`DRE_CTRL_PF_DIS] : iniPrefSpace)); // [R24]

	wire [2:0]  hit;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi = gi + 1) begin : gMatch
			assign hit[gi] = (gi < qCnt_q) && (eAddr[gi] == iniAddr) && cmdMatch(eCmd[gi], iniCmd);
		end
	endgenerate

	// Initiator-side decisions
	wire        reqNew    = iniReq && !busy_q;
	wire        ftOk      = (tState_q == TS_DATA) && ePref[0] && !killFetch_q &&
		(remain_q != 7'd0) && (bufCnt_q != 6'd0); // [R16]
	wire        doAbort   = reqNew && hit[0] && headAbort_q;
	wire        doDeliver = reqNew && hit[0] && !headAbort_q && rdOrderOk && (headDone_q || ftOk); // [R13]
	wire        doAdd     = reqNew && (hit == 3'b000) && (qCnt_q != `DRE_QUEUE_DEPTH); // [R22]
	wire        doRetry   = iniReq && !doAbort && !doDeliver; // [R3]

	wire        canRead   = busy_q && !iniStop && iniTake && (bufCnt_q != 6'd0);
	wire        lastRead  = canRead && (bufCnt_q == 6'd1) && headDone_q; // [R15]
	wire        emptyEnd  = busy_q && !iniStop && (bufCnt_q == 6'd0) && headDone_q;
	wire        iniEnd    = busy_q && iniStop;

	// Target-side events
	wire        inData    = tState_q == TS_DATA;
	wire        accept    = inData && tgtDataValid && !killFetch_q &&
		(flow_q || remain_q != 7'd0) && (bufCnt_q != `DRE_BUF_DEPTH);
	wire        limitHit  = inData && tgtRetry && (attempts_q == RETRY_LIMIT - 25'd1); // [R9]
	wire        discardExp = headDone_q && !busy_q && (qCnt_q != 2'd0) && (discard_q == 16'd1); // [R21]

	wire        dropHead  = doAbort || lastRead || emptyEnd || iniEnd || discardExp;
	wire        wr        = accept;
	wire        rd        = canRead;
	wire [5:0]  bufNext   = iniEnd || discardExp ? 6'd0 : bufCnt_q + {5'd0, wr} - {5'd0, rd};
	wire [1:0]  addIdx    = qCnt_q - {1'b0, dropHead};
	wire [6:0]  remNext   = remain_q - {6'd0, accept};
	wire [31:0] adrNext   = accept ? fetchAddr_q + 32'd4 : fetchAddr_q;

	// Ask the master to end after the current data phase
	wire        stopNext  = killFetch_q || iniEnd ||
		(flow_q ? ((adrNext[11:2] == 10'h3ff) || (bufNext >= `DRE_BUF_DEPTH - 6'd1)) // [R17]
		        : (remNext <= 7'd1));

	integer i;

	// APB slave, one wait state
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ctrl_q  <= `DRE_CTRL_RST;
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && (paddr != `DRE_CTRL_OFS) && (paddr != `DRE_STAT_OFS);
			if (psel && penable && pready && pwrite && (paddr == `DRE_CTRL_OFS))
				ctrl_q <= pwdata & `DRE_CTRL_MASK;
			if (psel && penable && !pready && !pwrite) begin
				prdata <= 32'h0000_0000;
				if (paddr == `DRE_CTRL_OFS)
					prdata <= ctrl_q;
				else if (paddr == `DRE_STAT_OFS) begin
					prdata[`DRE_STAT_QCNT_HI:`DRE_STAT_QCNT_LO] <= qCnt_q;
					prdata[`DRE_STAT_FLOW]                      <= flow_q;
					prdata[`DRE_STAT_DONE]                      <= headDone_q;
					prdata[`DRE_STAT_ABORT]                     <= headAbort_q;
					prdata[`DRE_STAT_TST_HI:`DRE_STAT_TST_LO]   <= tState_q;
					prdata[`DRE_STAT_BCNT_HI:`DRE_STAT_BCNT_LO] <= bufCnt_q;
				end
			end
		end
	end

	// Delayed transaction queue; entry 0 is the head
	always @(posedge ref_clk) begin
		if (dropHead) begin
			for (i = 0; i < 2; i = i + 1) begin
				eAddr[i] <= eAddr[i + 1];
				eCmd[i]  <= eCmd[i + 1];
				ePar[i]  <= ePar[i + 1];
				eBe[i]   <= eBe[i + 1];
				ePref[i] <= ePref[i + 1];
			end
		end
		if (doAdd) begin
			eAddr[addIdx] <= iniAddr; // [R2]
			eCmd[addIdx]  <= iniCmd;
			ePar[addIdx]  <= iniPar;
			eBe[addIdx]   <= iniBe;
			ePref[addIdx] <= newPref;
		end
	end

	// Read data buffer toward the initiator bus
	always @(posedge ref_clk) begin
		if (wr)
			buf_q[wrPtr_q] <= tgtData; // [R11]
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			qCnt_q   <= 2'd0;
			wrPtr_q  <= 5'd0;
			rdPtr_q  <= 5'd0;
			bufCnt_q <= 6'd0;
		end else begin
			qCnt_q   <= qCnt_q - {1'b0, dropHead} + {1'b0, doAdd}; // [R1]
			bufCnt_q <= bufNext;
			if (iniEnd || discardExp) begin
				wrPtr_q <= 5'd0; // [R19]
				rdPtr_q <= 5'd0;
			end else begin
				wrPtr_q <= wrPtr_q + {4'd0, wr}; // [R12]
				rdPtr_q <= rdPtr_q + {4'd0, rd};
			end
		end
	end

	// Master on the target bus
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			tState_q    <= TS_IDLE;
			tgtReq      <= 1'b0;
			tgtStart    <= 1'b0;
			tgtAddr     <= 32'h0000_0000;
			tgtCmd      <= 4'h0;
			tgtBe       <= 4'h0;
			tgtPar      <= 1'b0;
			tgtLast     <= 1'b0;
			remain_q    <= 7'd0;
			fetchAddr_q <= 32'h0000_0000;
			attempts_q  <= 25'd0;
			headDone_q  <= 1'b0;
			headAbort_q <= 1'b0;
			killFetch_q <= 1'b0;
		end else begin
			tgtStart <= 1'b0;
			if (dropHead) begin
				headDone_q  <= 1'b0;
				headAbort_q <= 1'b0;
				attempts_q  <= 25'd0;
			end
			if (iniEnd && inData)
				killFetch_q <= 1'b1; // [R19]
			case (tState_q)
				TS_IDLE: begin
					tgtLast <= 1'b0;
					if ((qCnt_q != 2'd0) && !dropHead && !headDone_q && pwDrained && (bufCnt_q == 6'd0)) begin
						tgtReq   <= 1'b1; // [R5]
						tState_q <= TS_ARB;
					end
				end
				TS_ARB: begin
					if (tgtGnt) begin
						tgtReq      <= 1'b0;
						tgtStart    <= 1'b1;
						tgtAddr     <= eAddr[0]; // [R5]
						tgtCmd      <= eCmd[0];
						tgtPar      <= ePar[0];
						tgtBe       <= ePref[0] ? 4'h0 : eBe[0]; // [R6]
						fetchAddr_q <= eAddr[0];
						remain_q    <= fetchLimit(ePref[0], eCmd[0], cache_line_size_setting, eAddr[0][7:2]);
						tgtLast     <= fetchLimit(ePref[0], eCmd[0], cache_line_size_setting, eAddr[0][7:2]) <= 7'd1;
						tState_q    <= TS_DATA;
					end
				end
				TS_DATA: begin
					remain_q    <= remNext;
					fetchAddr_q <= adrNext;
					tgtLast     <= stopNext;
					if (tgtAbort) begin
						headAbort_q <= !killFetch_q;
						headDone_q  <= !killFetch_q;
						killFetch_q <= 1'b0;
						tState_q    <= TS_IDLE;
					end else if (tgtRetry) begin
						if (limitHit) begin
							headAbort_q <= 1'b1; // [R9]
							headDone_q  <= 1'b1;
						end else
							attempts_q <= attempts_q + 25'd1; // [R7]
						killFetch_q <= 1'b0;
						tState_q    <= TS_IDLE;
					end else if (tgtEnd) begin
						headDone_q  <= !killFetch_q && !(iniEnd && flow_q); // [R8]
						killFetch_q <= 1'b0;
						tState_q    <= TS_IDLE;
					end
				end
				default: tState_q <= TS_IDLE;
			endcase
		end
	end

	// Initiator-side answers and discard timer
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			iniRetry  <= 1'b0;
			iniAbort  <= 1'b0;
			iniTrdy   <= 1'b0;
			iniData   <= 32'h0000_0000;
			iniDisc   <= 1'b0;
			busy_q    <= 1'b0;
			flow_q    <= 1'b0;
			discard_q <= DISCARD_SHORT;
			sysErrN   <= 1'b1;
		end else begin
			iniRetry <= doRetry; // [R3]
			iniAbort <= doAbort; // [R9]
			iniTrdy  <= canRead; // [R18]
			iniDisc  <= lastRead || emptyEnd; // [R15]
			if (canRead)
				iniData <= buf_q[rdPtr_q];
			if (doDeliver) begin
				busy_q <= 1'b1;
				flow_q <= !headDone_q; // [R16]
			end else if (lastRead || emptyEnd || iniEnd) begin
				busy_q <= 1'b0;
				flow_q <= 1'b0;
			end
			if (headDone_q && !busy_q && !dropHead && (qCnt_q != 2'd0))
				discard_q <= discard_q - 16'd1; // [R20]
			else
				discard_q <= mtoSel ? DISCARD_LONG : DISCARD_SHORT; // [R26]
			sysErrN <= !((limitHit && serrEn) || // [R10]
				(discardExp && serrEn && ctrl_q[`DRE_CTRL_DSERR_EN])); // [R21]
		end
	end

endmodule // dre_read_engine

/* File: tb/dre_read_engine_monitor.sv */
`timescale 1ns/100ps
module dre_read_engine_monitor (
	input wire        ref_clk,
	input wire        reset_n,
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [7:0]  paddr,
	input wire [31:0] pwdata,
	input wire        pready,
	input wire        iniReq,
	input wire        iniTake,
	input wire        iniRetry,
	input wire        iniAbort,
	input wire        iniTrdy,
	input wire        iniDisc,
	input wire        tgtReq,
	input wire        tgtGnt,
	input wire        tgtStart,
	input wire [3:0]  tgtBe,
	input wire        tgtLast,
	input wire        sysErrN
);
	reg serrEn_q;
	// Shadow of the enable bit, rebuilt from bus writes
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n)
			serrEn_q <= 1'b0;
		else if (psel && penable && pready && pwrite && paddr == 8'h00)
			serrEn_q <= pwdata[0];
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_retry; iniRetry |-> $past(iniReq); endproperty
	a_retry: assert property (p_retry) else $error("retry without request");
	property p_abort; iniAbort |-> $past(iniReq) && !iniRetry; endproperty
	a_abort: assert property (p_abort) else $error("abort without request");
	property p_start; tgtStart |-> $past(tgtReq) && $past(tgtGnt); endproperty
	a_start: assert property (p_start) else $error("start without grant");
	property p_hold; tgtReq && !tgtGnt |=> tgtReq; endproperty
	a_hold: assert property (p_hold) else $error("request dropped early");
	property p_pfbe; tgtStart && !tgtLast |-> tgtBe == 4'h0; endproperty
	a_pfbe: assert property (p_pfbe) else $error("prefetch enables not zero");
	property p_trdy; iniTrdy |-> $past(iniTake); endproperty
	a_trdy: assert property (p_trdy) else $error("data without initiator ready");
	property p_serr; !sysErrN |-> serrEn_q ##1 sysErrN; endproperty
	a_serr: assert property (p_serr) else $error("system error not allowed");
	property p_wait; psel && penable && !pready |=> pready ##1 !pready; endproperty
	a_wait: assert property (p_wait) else $error("bus answer timing wrong");
	cover property (iniTrdy && iniDisc);
	cover property (tgtStart && !tgtLast);
	cover property (!sysErrN);
endmodule // dre_read_engine_monitor

bind dre_read_engine dre_read_engine_monitor dre_read_engine_monitor_inst (.ref_clk, .reset_n, .psel, .penable,
	.pwrite, .paddr, .pwdata, .pready, .iniReq, .iniTake, .iniRetry, .iniAbort, .iniTrdy, .iniDisc, .tgtReq,
	.tgtGnt, .tgtStart, .tgtBe, .tgtLast, .sysErrN);

/* File: tb/dre_target_model.sv */
`timescale 1ns/100ps
module dre_target_model (
	input wire        ref_clk,
	input wire        reset_n,
	input wire [1:0]  mode,
	input wire [5:0]  maxDw,
	input wire        tgtReq,
	input wire        tgtStart,
	input wire [31:0] tgtAddr,
	input wire        tgtLast,
	output reg        tgtGnt,
	output reg [31:0] tgtData,
	output reg        tgtDataValid,
	output reg        tgtRetry,
	output reg        tgtAbort,
	output reg        tgtEnd
);
	reg        run_q;
	reg        fin_q;
	reg [5:0]  cnt_q;
	reg [31:0] addr_q;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			{tgtGnt, tgtDataValid, tgtRetry, tgtAbort, tgtEnd, run_q, fin_q} <= 7'h00;
			cnt_q <= 6'h00;
			addr_q <= 32'h0;
			tgtData <= 32'h0;
		end else begin
			tgtGnt <= tgtReq && !run_q;
			{tgtDataValid, tgtRetry, tgtAbort, tgtEnd} <= 4'h0;
			// Idle data toggles so a stale word never passes for a fresh one
			tgtData <= ~tgtData;
			if (tgtStart) begin
				tgtRetry <= mode == 2'd1;
				tgtAbort <= mode == 2'd2;
				run_q <= mode == 2'd0;
				fin_q <= 1'b0;
				cnt_q <= 6'h00;
				addr_q <= tgtAddr;
			end else if (run_q && (fin_q || cnt_q == maxDw)) begin
				tgtEnd <= 1'b1;
				run_q <= 1'b0;
			end else if (run_q) begin
				tgtDataValid <= 1'b1;
				tgtData <= addr_q;
				addr_q <= addr_q + 32'h4;
				cnt_q <= cnt_q + 6'h1;
				fin_q <= tgtLast;
			end
		end
	end
endmodule // dre_target_model

/* File: tb/testbench.sv */
`timescale 1ns/100ps
module testbench;
	logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, iniAddr = 0, iniData, tgtAddr, tgtData, addrSeen;
	logic pready, pslverr, iniReq = 0, iniPar = 0, iniTake = 0, iniRetry, iniAbort, iniTrdy, iniDisc;
	logic [3:0] iniCmd = 0, iniBe = 0, tgtCmd, tgtBe, beSeen, cmdSeen;
	logic tgtGnt, tgtDataValid, tgtRetry, tgtAbort, tgtEnd, tgtReq, tgtStart, tgtPar, tgtLast, sysErrN;
	logic [1:0] mode = 0;
	logic parSeen;
	logic [5:0] maxDw = 6'h3f;
	integer miscompares = 0, checked = 0, starts = 0, t;
	// Order gates held open and iniStop held low; the initiator-stop path is not under test
	wire iniPrefSpace = 1'b0, iniStop = 1'b0, rdOrderOk = 1'b1, pwDrained = 1'b1;
	always #25 ref_clk = ~ref_clk;
	dre_read_engine #(.RETRY_LIMIT(25'd4), .DISCARD_SHORT(16'd200), .DISCARD_LONG(16'd100)) dre_read_engine_inst (
		.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .iniReq,
		.iniAddr, .iniCmd, .iniPar, .iniBe, .iniPrefSpace, .iniTake, .iniStop, .rdOrderOk, .iniRetry, .iniAbort,
		.iniTrdy, .iniData, .iniDisc, .pwDrained, .tgtGnt, .tgtData, .tgtDataValid, .tgtRetry, .tgtAbort, .tgtEnd,
		.tgtReq, .tgtStart, .tgtAddr, .tgtCmd, .tgtBe, .tgtPar, .tgtLast, .sysErrN);
	dre_target_model dre_target_model_inst (.ref_clk, .reset_n, .mode, .maxDw, .tgtReq, .tgtStart, .tgtAddr,
		.tgtLast, .tgtGnt, .tgtData, .tgtDataValid, .tgtRetry, .tgtAbort, .tgtEnd);
	always @(posedge ref_clk) begin
		if (tgtStart === 1'b1) begin
			starts <= starts + 1;
			beSeen <= tgtBe;
			cmdSeen <= tgtCmd;
			addrSeen <= tgtAddr;
			parSeen <= tgtPar;
		end
	end
	task chk(input string n, input [31:0] s, input [31:0] e);
		checked = checked + 1;
		if (s !== e) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task finish_test;
		$display("checks %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task apb(input w, input [7:0] a, input [31:0] d, input [31:0] e, input er);
		integer i;
		@(posedge ref_clk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		for (i = 0; i < 20 && pready !== 1'b1; i = i + 1) @(posedge ref_clk);
		if (i == 20) begin
			miscompares = miscompares + 1;
			finish_test;
		end
		psel <= 0;
		penable <= 0;
		if (!w) chk("prdata", prdata, e);
		chk("pslverr", {31'h0, pslverr}, {31'h0, er});
	endtask
	// w: 0 expects retry, 1 abort, 2 a burst of n words
	task rd(input [31:0] a, input [3:0] c, input [1:0] w, input integer n);
		integer i, k;
		@(posedge ref_clk);
		iniReq <= 1;
		iniAddr <= a;
		iniCmd <= c;
		iniBe <= 4'h5;
		iniPar <= ^{a, c};
		iniTake <= w == 2;
		@(posedge ref_clk);
		iniReq <= 0;
		@(posedge ref_clk);
		k = 0;
		if (w == 0) chk("retry", {31'h0, iniRetry}, 1);
		if (w == 1) chk("abort", {31'h0, iniAbort}, 1);
		for (i = 0; w == 2 && i < 300; i = i + 1) begin
			if (iniTrdy === 1'b1) begin
				chk("data", iniData, a + 4 * k);
				k = k + 1;
			end
			if (iniDisc === 1'b1) i = 300;
			else @(posedge ref_clk);
		end
		iniTake <= 0;
		if (w == 2 && i == 300) begin
			miscompares = miscompares + 1;
			finish_test;
		end
		if (w == 2) chk("count", k, n);
	endtask
	task waitEv(input integer w);
		integer i;
		for (i = 0; i < 400 && !(w ? sysErrN === 1'b0 : tgtEnd === 1'b1); i = i + 1) @(posedge ref_clk);
		if (i == 400) begin
			miscompares = miscompares + 1;
			finish_test;
		end
		repeat (2) @(posedge ref_clk);
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		reset_n <= 1;
		apb(1, 8'h00, 32'hffff_ffff, 0, 0);
		apb(0, 8'h00, 0, 32'h0000_ff1f, 0);
		apb(0, 8'h08, 0, 0, 1);
		apb(1, 8'h00, 32'h0000_0001, 0, 0);
		$display("register test done");
		rd(32'h0000_0040, 4'h2, 0, 0);
		waitEv(0);
		chk("be", beSeen, 4'h5);
		chk("addr", addrSeen, 32'h0000_0040);
		chk("cmd", cmdSeen, 4'h2);
		rd(32'h0000_0040, 4'h2, 2, 1);
		$display("single word test done");
		for (t = 0; t < 2; t = t + 1) begin
			maxDw <= t ? 6'd3 : 6'd63;
			rd(t ? 32'h1000_0100 : 32'h1000_0020, 4'he, 0, 0);
			waitEv(0);
			chk("pfbe", beSeen, 4'h0);
			rd(t ? 32'h1000_0100 : 32'h1000_0020, 4'h6, 2, t ? 3 : 8);
			chk("starts", starts, 2 + t);
		end
		$display("prefetch test done");
		rd(32'h0000_0080, 4'h2, 0, 0);
		rd(32'h0000_0080, 4'h2, 0, 0);
		waitEv(0);
		repeat (230) @(posedge ref_clk);
		rd(32'h0000_0080, 4'h2, 0, 0);
		waitEv(0);
		rd(32'h0000_0080, 4'h2, 2, 1);
		$display("discard test done");
		// Repeat lands while the fetch still runs, so data flows past the 32-word limit
		maxDw <= 6'd40;
		rd(32'h2000_0000, 4'hc, 0, 0);
		repeat (8) @(posedge ref_clk);
		rd(32'h2000_0000, 4'h6, 2, 40);
		$display("flow-through test done");
		mode <= 1;
		rd(32'h0000_00c0, 4'h2, 0, 0);
		waitEv(1);
		chk("par", {31'h0, parSeen}, 1);
		rd(32'h0000_00c0, 4'h2, 1, 0);
		chk("starts", starts, 10);
		mode <= 2;
		rd(32'h0000_0100, 4'h2, 0, 0);
		repeat (12) @(posedge ref_clk);
		rd(32'h0000_0100, 4'h2, 1, 0);
		chk("starts", starts, 11);
		$display("retry limit test done");
		finish_test;
	end
endmodule // testbench
